// *** hdl/acq_link_defines.svh ***
// Register indices, field positions and reset values of the link controller
`ifndef ACQ_LINK_DEFINES_SVH
`define ACQ_LINK_DEFINES_SVH
// ****************************************************************
// Word indices inside the register page (byte offset / 2)
// ****************************************************************
`define IDX_IMM_ADDR    5'h02
`define IDX_IMM_DATA    5'h03
`define IDX_IMM_MODULE  5'h04
`define IDX_IMM_BUSY    5'h05
`define IDX_IRQ_SOURCE  5'h06
`define IDX_IRQ_DATA    5'h07
`define IDX_ASSIGN_A    5'h08
`define IDX_ASSIGN_B    5'h09
`define IDX_DIAG        5'h0a
`define IDX_PTR_A       5'h0b
`define IDX_PTR_B       5'h0c
// ****************************************************************
// Field positions
// ****************************************************************
`define BIT_IMM_READ    15
`define BIT_DIAG_MODE   0
`define BIT_DIAG_IRQ    1
`define BIT_DIAG_XFER   2
`define BIT_IRQ_PEND    4
`define BIT_TC_A        5
`define BIT_TC_B        6
`define BIT_ASSIGNED    5
`define BIT_PAGE_REGS   14
// ****************************************************************
// Reset values and frame lengths
// ****************************************************************
`define RST_WORD        16'h0000
`define RST_PTR         13'h0000
`define CMD_BITS        6'h25
`define HDR_BITS        6'h15
`define IRQ_BITS        6'h14
`define WORD_BITS       6'h10
`define DIAG_CYCLES     6'h08
`endif

// *** hdl/acq_link_pkg.sv ***
// Types shared by the link controller
package acq_link_pkg;
    typedef enum logic [2:0] {L_IDLE, L_CMD, L_RD, L_IRQ, L_DIAG} link_state_t;
    typedef enum logic [0:0] {X_IDLE, X_COPY} xfer_state_t;
    // Buffer assignment word
    typedef struct packed {
        logic [9:0] rsvd;
        logic       assigned;
        logic       dir_read;
        logic [3:0] module_num;
    } buf_assign_t;
    // Processor bus request captured on the strobe
    typedef struct packed {
        logic        rw;
        logic [14:1] addr;
        logic [15:0] wdata;
    } cpu_req_t;
endpackage

// *** hdl/acq_link_host.sv ***
// Host link controller: immediate commands, module interrupts, buffers
`timescale 1ns/1ns
`include "acq_link_defines.svh"
module acq_link_host #(
    parameter int XFER_WORDS = 4096
) (
    input  wire logic                   sys_clk,
    input  wire logic                   resetn,
    input  wire logic                   cpu_strobe,
    input  wire logic                   cpu_rw,
    input  wire logic [14:1]            cpu_bus_addr,
    input  wire logic [15:0]            cpu_bus_data_in,
    output      logic [15:0]            cpu_bus_data_out,
    output      logic                   cpu_bus_data_oe,
    output      logic                   cpu_ack,
    output      logic                   link_irq_line,
    input  wire logic                   link_clk,
    input  wire logic                   link_data_in,
    output      logic                   link_data_out,
    output      logic                   link_data_oe,
    input  wire logic                   handshake_line_in,
    output      logic                   handshake_line_out,
    output      logic                   handshake_line_oe
);
    import acq_link_pkg::*;

    // ****************************************************************
    // Reset release and input synchronisers
    // ****************************************************************
    logic       rst_s1_q, rst_n;
    logic [2:0] sync1_q, sync2_q;
    logic       lclk_prev_q;
    logic       link_rise;

    // Reset asserts at once and releases through two flops
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            rst_s1_q <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n    <= rst_s1_q;
        end
    end

    // Link pins pass two flops; edge found on the second stage
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_q     <= 3'h0;
            sync2_q     <= 3'h0;
            lclk_prev_q <= 1'b0;
        end else begin
            sync1_q     <= {link_clk, link_data_in, handshake_line_in};
            sync2_q     <= sync1_q;
            lclk_prev_q <= sync2_q[2];
        end
    end
    assign link_rise = sync2_q[2] & ~lclk_prev_q;

    // ****************************************************************
    // State
    // ****************************************************************
    logic [15:0] mem [0:8191];
    cpu_req_t    req_q, req_d;
    logic        req_v_q, req_v_d;
    logic [15:0] imm_addr_q, imm_addr_d, imm_data_q, imm_data_d;
    logic [3:0]  imm_mod_q, imm_mod_d, irq_mod_q, irq_mod_d;
    logic [3:0]  grant_q, grant_d;
    logic        grant_v_q, grant_v_d, busy_q, busy_d;
    logic        pend_q, pend_d, tc_a_q, tc_a_d, tc_b_q, tc_b_d;
    logic [15:0] irq_data_q, irq_data_d, diag_q, diag_d;
    logic [15:0] diag_data_q, diag_data_d;
    buf_assign_t asg_a_q, asg_a_d, asg_b_q, asg_b_d;
    logic [12:0] ptr_a_q, ptr_a_d, ptr_b_q, ptr_b_d;
    link_state_t lst_q, lst_d;
    logic [36:0] shift_q, shift_d;
    logic [5:0]  cnt_q, cnt_d;
    xfer_state_t xst_q, xst_d;
    logic [12:0] xcnt_q, xcnt_d;
    logic        a_to_b_q, a_to_b_d;
    logic [15:0] rdata_d, bus_out_q;
    logic        ack_q, ack_d, irq_q, irq_d;
    logic        oe_q, oe_d;
    logic        ld_out_q, ld_out_d, ld_oe_q, ld_oe_d;
    logic        hs_out_q, hs_out_d, hs_oe_q, hs_oe_d;
    logic        ram_we;
    logic [12:0] ram_a, ram_ra;
    logic [15:0] ram_wd, ram_rd, src_word;
    logic        is_reg, wr_hit, rd_hit, dmode;
    logic [4:0]  idx;

    // Register page hit for one index
    function automatic logic hit(input cpu_req_t r, input logic [4:0] i);
        hit = r.addr[`BIT_PAGE_REGS] && (r.addr[5:1] == i);
    endfunction

    // ****************************************************************
    // Next-state logic
    // ****************************************************************
    always_comb begin
        req_d = cpu_req_t'({cpu_rw, cpu_bus_addr, cpu_bus_data_in});
        req_v_d = cpu_strobe;
        imm_addr_d = imm_addr_q;  imm_data_d = imm_data_q;
        imm_mod_d = imm_mod_q;    irq_mod_d = irq_mod_q;
        grant_d = grant_q;        grant_v_d = grant_v_q;
        busy_d = busy_q;          pend_d = pend_q;
        tc_a_d = tc_a_q;          tc_b_d = tc_b_q;
        irq_data_d = irq_data_q;  diag_d = diag_q;
        diag_data_d = diag_data_q;
        asg_a_d = asg_a_q;        asg_b_d = asg_b_q;
        ptr_a_d = ptr_a_q;        ptr_b_d = ptr_b_q;
        lst_d = lst_q;            shift_d = shift_q;
        cnt_d = cnt_q;            xst_d = xst_q;
        xcnt_d = xcnt_q;          a_to_b_d = a_to_b_q;
        dmode = diag_q[`BIT_DIAG_MODE];
        idx = req_q.addr[5:1];
        is_reg = req_q.addr[`BIT_PAGE_REGS];
        wr_hit = req_v_q && !req_q.rw;
        rd_hit = req_v_q && req_q.rw;
        ram_ra = req_q.addr[13:1];
        ram_we = wr_hit && !is_reg;
        ram_a = req_q.addr[13:1];
        ram_wd = req_q.wdata;
        src_word = 16'h0000;
        rdata_d = bus_out_q;
        // Buffer copy writes the RAM only in cycles with no processor request of any kind
        if (xst_q == X_COPY) begin
            ram_ra = a_to_b_q ? ptr_a_q + xcnt_q : ptr_b_q + xcnt_q;
            src_word = mem[ram_ra];
            if (!req_v_q) begin
                ram_we = 1'b1;
                ram_wd = src_word;
                ram_a = a_to_b_q ? ptr_b_q + xcnt_q : ptr_a_q + xcnt_q;
                xcnt_d = xcnt_q + 13'h0001;
                if (xcnt_q == 13'(XFER_WORDS - 1)) begin
                    xst_d = X_IDLE;
                    asg_a_d.assigned = 1'b0;
                    asg_b_d.assigned = 1'b0;
                    tc_a_d = 1'b1;
                    tc_b_d = 1'b1;
                end
            end
        end
        // Processor port keeps its own address while a copy runs
        ram_rd = mem[req_q.addr[13:1]];
        // Processor reads and their side effects; a new event wins
        if (rd_hit) begin
            rdata_d = ram_rd;
            if (is_reg) begin
                case (idx)
                    `IDX_IMM_ADDR:   rdata_d = imm_addr_q;
                    `IDX_IMM_DATA:   rdata_d = imm_data_q;
                    `IDX_IMM_MODULE: rdata_d = {12'h000, imm_mod_q};
                    `IDX_IMM_BUSY:   rdata_d = {15'h0000, busy_q};
                    `IDX_IRQ_SOURCE: begin
                        rdata_d = {9'h000, tc_b_q, tc_a_q, pend_q,
                                   irq_mod_q};
                        tc_a_d = 1'b0;
                        tc_b_d = 1'b0;
                    end
                    `IDX_IRQ_DATA: begin
                        rdata_d = irq_data_q;
                        pend_d = 1'b0;
                    end
                    `IDX_ASSIGN_A:   rdata_d = asg_a_q;
                    `IDX_ASSIGN_B:   rdata_d = asg_b_q;
                    `IDX_DIAG:       rdata_d = diag_q;
                    `IDX_PTR_A:      rdata_d = {3'h0, ptr_a_q};
                    `IDX_PTR_B:      rdata_d = {3'h0, ptr_b_q};
                    default:         rdata_d = 16'h0000;
                endcase
            end
        end
        // Processor register writes
        if (wr_hit && is_reg) begin
            if (!busy_q) begin
                if (hit(req_q, `IDX_IMM_ADDR)) imm_addr_d = req_q.wdata;
                if (hit(req_q, `IDX_IMM_DATA)) imm_data_d = req_q.wdata;
                if (hit(req_q, `IDX_IMM_MODULE)) begin
                    imm_mod_d = req_q.wdata[3:0];
                    busy_d = 1'b1;
                    shift_d = {imm_addr_q[`BIT_IMM_READ],
                               req_q.wdata[3:0], imm_addr_q, imm_data_q};
                    cnt_d = 6'h00;
                    lst_d = dmode ? L_DIAG : L_CMD;
                end
            end
            if (hit(req_q, `IDX_ASSIGN_A)) asg_a_d = req_q.wdata;
            if (hit(req_q, `IDX_ASSIGN_B)) asg_b_d = req_q.wdata;
            if (hit(req_q, `IDX_PTR_A)) ptr_a_d = req_q.wdata[12:0];
            if (hit(req_q, `IDX_PTR_B)) ptr_b_d = req_q.wdata[12:0];
            if (hit(req_q, `IDX_DIAG)) begin
                diag_d = req_q.wdata;
                if (req_q.wdata[`BIT_DIAG_MODE] &&
                    req_q.wdata[`BIT_DIAG_IRQ] && grant_v_q) begin
                    pend_d = 1'b1;
                    irq_mod_d = grant_q;
                    irq_data_d = diag_data_q;
                end
                if (req_q.wdata[`BIT_DIAG_MODE] &&
                    req_q.wdata[`BIT_DIAG_XFER] && xst_q == X_IDLE) begin
                    xst_d = X_COPY;
                    xcnt_d = 13'h0000;
                    a_to_b_d = asg_a_q.dir_read;
                end
            end
        end
        // Link sequencer
        case (lst_q)
            L_IDLE: begin
                if (!dmode && link_rise && sync2_q[0]) begin
                    lst_d = L_IRQ;
                    cnt_d = 6'h00;
                end
            end
            L_DIAG: begin
                // Loopback holds busy for a short frame so software sees it
                cnt_d = cnt_q + 6'h01;
                if (cnt_d == `DIAG_CYCLES) begin
                    // The grant and, on a write, the word are kept for replay
                    grant_d = imm_mod_q;
                    grant_v_d = 1'b1;
                    if (imm_addr_q[`BIT_IMM_READ])
                        imm_data_d = imm_addr_q;
                    else
                        diag_data_d = imm_data_q;
                    busy_d = 1'b0;
                    lst_d = L_IDLE;
                end
            end
            L_CMD: begin
                if (link_rise) begin
                    shift_d = {shift_q[35:0], 1'b0};
                    cnt_d = cnt_q + 6'h01;
                    // Address is locked while busy, so its read bit holds
                    if (imm_addr_q[`BIT_IMM_READ] && cnt_d == `HDR_BITS) begin
                        lst_d = L_RD;
                        cnt_d = 6'h00;
                    end else if (cnt_d == `CMD_BITS) begin
                        busy_d = 1'b0;
                        lst_d = L_IDLE;
                    end
                end
            end
            L_RD: begin
                if (link_rise) begin
                    imm_data_d = {imm_data_q[14:0], sync2_q[1]};
                    cnt_d = cnt_q + 6'h01;
                    if (cnt_d == `WORD_BITS) begin
                        busy_d = 1'b0;
                        lst_d = L_IDLE;
                    end
                end
            end
            L_IRQ: begin
                if (link_rise) begin
                    shift_d = {shift_q[35:0], sync2_q[1]};
                    cnt_d = cnt_q + 6'h01;
                    if (cnt_d == `IRQ_BITS) begin
                        pend_d = 1'b1;
                        irq_mod_d = shift_q[18:15];
                        irq_data_d = {shift_q[14:0], sync2_q[1]};
                        lst_d = L_IDLE;
                    end
                end
            end
            default: lst_d = L_IDLE;
        endcase
        // Outputs; diag mode floats every link driver
        irq_d = pend_d | tc_a_d | tc_b_d;
        ld_out_d = (lst_q == L_CMD && link_rise) ? shift_q[36] : ld_out_q;
        ld_oe_d = !diag_d[`BIT_DIAG_MODE] && lst_d == L_CMD;
        hs_out_d = lst_d == L_CMD;
        hs_oe_d = !diag_d[`BIT_DIAG_MODE];
        ack_d = req_v_q;
        oe_d = req_v_q && req_q.rw;
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    always_ff @(posedge sys_clk) begin
        if (ram_we)
            mem[ram_a] <= ram_wd;
    end

    // State registers
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            req_q <= '0;           req_v_q <= 1'b0;
            imm_addr_q <= `RST_WORD; imm_data_q <= `RST_WORD;
            imm_mod_q <= 4'h0;     irq_mod_q <= 4'h0;
            grant_q <= 4'h0;       grant_v_q <= 1'b0;
            busy_q <= 1'b0;        pend_q <= 1'b0;
            tc_a_q <= 1'b0;        tc_b_q <= 1'b0;
            irq_data_q <= `RST_WORD; diag_q <= `RST_WORD;
            diag_data_q <= `RST_WORD;
            asg_a_q <= '0;         asg_b_q <= '0;
            ptr_a_q <= `RST_PTR;   ptr_b_q <= `RST_PTR;
            lst_q <= L_IDLE;       shift_q <= '0;
            cnt_q <= 6'h00;        xst_q <= X_IDLE;
            xcnt_q <= `RST_PTR;    a_to_b_q <= 1'b0;
            bus_out_q <= `RST_WORD; ack_q <= 1'b0;
            irq_q <= 1'b0;         ld_out_q <= 1'b0;
            ld_oe_q <= 1'b0;       hs_out_q <= 1'b0;
            hs_oe_q <= 1'b0;
            oe_q <= 1'b0;
        end else begin
            req_q <= req_d;        req_v_q <= req_v_d;
            imm_addr_q <= imm_addr_d; imm_data_q <= imm_data_d;
            imm_mod_q <= imm_mod_d; irq_mod_q <= irq_mod_d;
            grant_q <= grant_d;    grant_v_q <= grant_v_d;
            busy_q <= busy_d;      pend_q <= pend_d;
            tc_a_q <= tc_a_d;      tc_b_q <= tc_b_d;
            irq_data_q <= irq_data_d; diag_q <= diag_d;
            diag_data_q <= diag_data_d;
            asg_a_q <= asg_a_d;    asg_b_q <= asg_b_d;
            ptr_a_q <= ptr_a_d;    ptr_b_q <= ptr_b_d;
            lst_q <= lst_d;        shift_q <= shift_d;
            cnt_q <= cnt_d;        xst_q <= xst_d;
            xcnt_q <= xcnt_d;      a_to_b_q <= a_to_b_d;
            bus_out_q <= rdata_d;  ack_q <= ack_d;
            irq_q <= irq_d;        ld_out_q <= ld_out_d;
            ld_oe_q <= ld_oe_d;    hs_out_q <= hs_out_d;
            hs_oe_q <= hs_oe_d;
            oe_q <= oe_d;
        end
    end

    assign cpu_bus_data_out   = bus_out_q;
    assign cpu_bus_data_oe    = oe_q;
    assign cpu_ack            = ack_q;
    assign link_irq_line      = irq_q;
    assign link_data_out      = ld_out_q;
    assign link_data_oe       = ld_oe_q;
    assign handshake_line_out = hs_out_q;
    assign handshake_line_oe  = hs_oe_q;
endmodule

// *** verif/acq_link_host_chk.sv ***
// Port assertions for the host link controller
`timescale 1ns/1ns
`include "acq_link_defines.svh"
module acq_link_host_chk (
    input wire logic        sys_clk,
    input wire logic        resetn,
    input wire logic        cpu_strobe,
    input wire logic        cpu_rw,
    input wire logic [14:1] cpu_bus_addr,
    input wire logic [15:0] cpu_bus_data_in,
    input wire logic [15:0] cpu_bus_data_out,
    input wire logic        cpu_bus_data_oe,
    input wire logic        cpu_ack,
    input wire logic        link_irq_line,
    input wire logic        link_data_oe,
    input wire logic        handshake_line_oe
);
    // ****************************************************************
    // Decode of a write to the diagnostic word
    // ****************************************************************
    logic diag_wr;
    assign diag_wr = cpu_strobe && !cpu_rw && cpu_bus_addr[14]
                     && cpu_bus_addr[5:1] == `IDX_DIAG;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    // ****************************************************************
    // Assertions
    // ****************************************************************
    ack_timing_a: assert property (cpu_strobe |-> ##2 cpu_ack)
        else $error("ack missing two cycles after strobe");
    ack_cause_a: assert property (cpu_ack |-> $past(cpu_strobe, 2))
        else $error("ack without a request");
    read_oe_a: assert property (cpu_ack
        |-> cpu_bus_data_oe == $past(cpu_rw, 2))
        else $error("data enable does not follow read");
    oe_gate_a: assert property (cpu_bus_data_oe |-> cpu_ack)
        else $error("data enable outside ack");
    data_hold_a: assert property (!(cpu_ack && cpu_bus_data_oe)
        |-> $stable(cpu_bus_data_out))
        else $error("read data moved without a read");
    diag_float_a: assert property (link_data_oe |-> handshake_line_oe)
        else $error("link driven in diagnostic mode");
    diag_oe_a: assert property (diag_wr
        |-> ##3 handshake_line_oe == !$past(cpu_bus_data_in[0], 3))
        else $error("handshake enable ignores mode bit");
    irq_raise_a: assert property (diag_wr
        && cpu_bus_data_in[1:0] == 2'b11 |-> ##[2:40] link_irq_line)
        else $error("diagnostic interrupt never raised");
endmodule
bind acq_link_host acq_link_host_chk chk_u (
    .sys_clk(sys_clk), .resetn(resetn), .cpu_strobe(cpu_strobe),
    .cpu_rw(cpu_rw), .cpu_bus_addr(cpu_bus_addr),
    .cpu_bus_data_in(cpu_bus_data_in), .cpu_bus_data_out(cpu_bus_data_out),
    .cpu_bus_data_oe(cpu_bus_data_oe), .cpu_ack(cpu_ack),
    .link_irq_line(link_irq_line), .link_data_oe(link_data_oe),
    .handshake_line_oe(handshake_line_oe));

// *** verif/acq_link_partner.sv ***
// Far-side acquisition module model: link clock and released lines
`timescale 1ns/1ns
module acq_link_partner (
    input  wire logic handshake_line_out,
    output      logic link_clk,
    output      logic link_data_in,
    output      logic handshake_line_in
);
    // Clock runs only within a command frame; data line never holds
    initial begin
        link_clk = 1'b0;
        link_data_in = 1'b0;
        handshake_line_in = 1'b0; // Pulled low: no unsolicited module interrupt frames
        forever begin
            #160;
            if (handshake_line_out === 1'b1 || link_clk) begin
                link_clk = ~link_clk;
            end
            link_data_in = ~link_data_in; // Released line toggles
        end
    end
endmodule

// *** verif/acq_link_host_tb.sv ***
// Self-checking bench for the host link controller
`timescale 1ns/1ns
`include "acq_link_defines.svh"
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin mismatches++; \
    $display("[FAIL] %0t got %h want %h", $time, (a), (e)); end end
module acq_link_host_tb;
    import acq_link_pkg::*;
    logic        sys_clk, resetn, cpu_strobe, cpu_rw, cpu_ack, cpu_bus_data_oe;
    logic [14:1] cpu_bus_addr;
    logic [15:0] cpu_bus_data_in, cpu_bus_data_out, q;
    logic        link_irq_line, link_clk, link_data_in, link_data_out;
    logic        link_data_oe, handshake_line_in, handshake_line_out;
    logic        handshake_line_oe;
    int          mismatches = 0;
    int          compares = 0;
    acq_link_host #(.XFER_WORDS(8)) dut_u (
        .sys_clk(sys_clk), .resetn(resetn), .cpu_strobe(cpu_strobe),
        .cpu_rw(cpu_rw), .cpu_bus_addr(cpu_bus_addr),
        .cpu_bus_data_in(cpu_bus_data_in), .cpu_bus_data_out(cpu_bus_data_out),
        .cpu_bus_data_oe(cpu_bus_data_oe), .cpu_ack(cpu_ack),
        .link_irq_line(link_irq_line), .link_clk(link_clk),
        .link_data_in(link_data_in), .link_data_out(link_data_out),
        .link_data_oe(link_data_oe), .handshake_line_in(handshake_line_in),
        .handshake_line_out(handshake_line_out),
        .handshake_line_oe(handshake_line_oe));
    acq_link_partner far_u (
        .handshake_line_out(handshake_line_out), .link_clk(link_clk),
        .link_data_in(link_data_in), .handshake_line_in(handshake_line_in));
    // ****************************************************************
    // Bus helpers
    // ****************************************************************
    function automatic logic [14:1] ra(input logic [4:0] idx);
        return {1'b1, 8'h00, idx};
    endfunction
    // One processor access; answer taken two edges after the strobe
    task automatic bus(input logic rw, input logic [14:1] a,
                       input logic [15:0] d);
        @(posedge sys_clk);
        cpu_strobe <= 1'b1;
        cpu_rw <= rw;
        cpu_bus_addr <= a;
        cpu_bus_data_in <= d;
        @(posedge sys_clk);
        cpu_strobe <= 1'b0;
        @(posedge sys_clk);
        #1;
        `CHK(cpu_ack, 1'b1)
        q = cpu_bus_data_out;
    endtask
    // Poll the busy flag under a bound
    task automatic wait_busy(input int n);
        int i;
        for (i = 0; i < n; i++) begin
            bus(1'b1, ra(`IDX_IMM_BUSY), 16'h0000);
            if (q[0] === 1'b0) break;
        end
        `CHK(q[0], 1'b0)
    endtask
    // Load and launch one immediate command
    task automatic imm(input logic [15:0] a, d, input logic [3:0] m);
        wait_busy(400);
        bus(1'b0, ra(`IDX_IMM_ADDR), a);
        bus(1'b0, ra(`IDX_IMM_DATA), d);
        bus(1'b0, ra(`IDX_IMM_MODULE), {12'h000, m});
        bus(1'b1, ra(`IDX_IMM_BUSY), 16'h0000);
        `CHK(q[0], 1'b1)
    endtask
    task automatic wait_irq;
        int i;
        for (i = 0; i < 200 && link_irq_line !== 1'b1; i++) begin
            @(posedge sys_clk);
            #1;
        end
        `CHK(link_irq_line, 1'b1)
    endtask
    // ****************************************************************
    // Scenarios
    // ****************************************************************
    // Diagnostic reads loop the address back into the data word
    task automatic t_imm_read;
        logic [15:0] pats [4] = '{16'hffff, 16'haaaa, 16'hb555, 16'h8000};
        bus(1'b0, ra(`IDX_DIAG), 16'h0001);
        `CHK(handshake_line_oe, 1'b0)
        `CHK(link_data_oe, 1'b0)
        foreach (pats[i]) begin
            imm(pats[i], 16'h0000, i[0] ? 4'h8 : 4'h0);
            wait_busy(10);
            bus(1'b1, ra(`IDX_IMM_DATA), 16'h0000);
            `CHK(q, pats[i])
        end
    endtask
    // Diagnostic write then replayed grant as module interrupt
    task automatic t_irq;
        logic [3:0] m;
        for (int k = 0; k < 2; k++) begin
            m = k ? 4'hb : 4'h2;
            imm(16'h0040, {12'h3c0, m}, m);
            wait_busy(10);
            bus(1'b0, ra(`IDX_DIAG), 16'h0003);
            wait_irq();
            bus(1'b1, ra(`IDX_IRQ_SOURCE), 16'h0000);
            `CHK(q[4:0], {1'b1, m})
            bus(1'b1, ra(`IDX_IRQ_DATA), 16'h0000);
            `CHK(q, {12'h3c0, m})
            bus(1'b1, ra(`IDX_IRQ_SOURCE), 16'h0000);
            `CHK(q[4], 1'b0)
            `CHK(link_irq_line, 1'b0)
        end
    endtask
    // Buffer copy from A to B with terminal-count interrupt
    task automatic t_buf;
        for (int i = 0; i < 8; i++) begin
            bus(1'b0, {1'b0, 13'(i)}, 16'h1000 + 16'(i));
            bus(1'b0, {1'b0, 13'(16 + i)}, 16'h0000);
        end
        bus(1'b0, {1'b0, 13'h1fff}, 16'ha5c3);
        bus(1'b1, {1'b0, 13'h1fff}, 16'h0000);
        `CHK(q, 16'ha5c3)
        bus(1'b0, ra(`IDX_PTR_A), 16'h0000);
        bus(1'b0, ra(`IDX_PTR_B), 16'h0010);
        bus(1'b1, ra(`IDX_PTR_B), 16'h0000);
        `CHK(q[12:0], 13'h0010)
        bus(1'b0, ra(`IDX_ASSIGN_A), 16'h0030);
        bus(1'b0, ra(`IDX_ASSIGN_B), 16'h0028);
        imm(16'h8000, 16'h0000, 4'h8);
        imm(16'h8000, 16'h0000, 4'h0);
        wait_busy(10);
        bus(1'b0, ra(`IDX_DIAG), 16'h0005);
        wait_irq();
        bus(1'b1, ra(`IDX_IRQ_SOURCE), 16'h0000);
        `CHK(q[6:5], 2'b11)
        bus(1'b1, ra(`IDX_IRQ_SOURCE), 16'h0000);
        `CHK(q[6:5], 2'b00)
        bus(1'b1, ra(`IDX_ASSIGN_A), 16'h0000);
        `CHK(q[5], 1'b0)
        `CHK(q[3:0], 4'h0)
        bus(1'b1, ra(`IDX_ASSIGN_B), 16'h0000);
        `CHK(q[5], 1'b0)
        `CHK(q[3:0], 4'h8)
        for (int i = 0; i < 8; i++) begin
            bus(1'b1, {1'b0, 13'(16 + i)}, 16'h0000);
            `CHK(q, 16'h1000 + 16'(i))
        end
    endtask
    // Normal mode: writes while busy leave the command untouched
    task automatic t_normal;
        bus(1'b0, ra(`IDX_DIAG), 16'h0000);
        `CHK(handshake_line_oe, 1'b1)
        bus(1'b1, ra(`IDX_PTR_B), 16'h0000);
        `CHK(q[12:0], 13'h0010)
        imm(16'h1234, 16'h00ab, 4'h3);
        `CHK(link_data_oe, 1'b1)
        `CHK(handshake_line_out, 1'b1)
        bus(1'b0, ra(`IDX_IMM_ADDR), 16'hbeef);
        bus(1'b0, ra(`IDX_IMM_DATA), 16'h5555);
        bus(1'b0, ra(`IDX_IMM_MODULE), 16'h0007);
        wait_busy(400);
        `CHK(handshake_line_out, 1'b0)
        `CHK(link_data_out, 1'b1)
        bus(1'b1, ra(`IDX_IMM_ADDR), 16'h0000);
        `CHK(q, 16'h1234)
        bus(1'b1, ra(`IDX_IMM_DATA), 16'h0000);
        `CHK(q, 16'h00ab)
    endtask
    // ****************************************************************
    // Clock, verdict, watchdog and main sequence
    // ****************************************************************
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    task automatic give_verdict;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        #400000;
        mismatches++;
        give_verdict();
    end
    initial begin
        resetn = 1'b0;
        cpu_strobe = 1'b0;
        cpu_rw = 1'b1;
        cpu_bus_addr = 14'h0000;
        cpu_bus_data_in = 16'h0000;
        repeat (2) @(posedge sys_clk);
        resetn <= 1'b1;
        repeat (3) @(posedge sys_clk);
        t_imm_read();
        t_irq();
        t_buf();
        t_normal();
        give_verdict();
    end
endmodule
